//--- inc/stp_pkg.sv
// Constants for the shared test pin controller.
// Assumes a single 10 MHz system clock and a sampled test clock.
package stp_pkg;
    // ********************************
    // Test controller states
    // ********************************
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHF_DR, ST_EX1_DR, ST_PAU_DR,
        ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHF_IR, ST_EX1_IR, ST_PAU_IR,
        ST_EX2_IR, ST_UPD_IR
    } stp_state_t;
    // ********************************
    // Widths and codes
    // ********************************
    localparam int unsigned STP_IR_W = 4;
    localparam int unsigned STP_DR_W = 8;
    localparam int unsigned STP_FIFO_DEPTH = 8;
    localparam logic [STP_IR_W-1:0] STP_IR_RESET = 4'h1;
    localparam logic [STP_IR_W-1:0] STP_IR_CHECKSUM = 4'hC;
    localparam logic [STP_IR_W-1:0] STP_IR_BYPASS = 4'hF;
    localparam logic [STP_DR_W-1:0] STP_DR_ZERO = 8'h00;
    localparam logic [STP_DR_W-1:0] STP_SUM_INIT = 8'h00;
    localparam logic [1:0] STP_SYNC_ZERO = 2'h0;
    localparam logic [1:0] STP_SYNC_ONE = 2'h3;
    // Five test clock rises with select high reach logic reset
    localparam int unsigned STP_RESET_TCKS = 5;
endpackage : stp_pkg

//--- rtl/stp_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module stp_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule : stp_fifo

//--- rtl/stp_ctrl.sv
// Shared test pin controller: pin ownership, test state machine, shifting.
// Assumes test pins arrive from outside and are sampled by clk at 10 MHz.
`timescale 1ns/1ps
module stp_ctrl
    import stp_pkg::*;
#(
    parameter bit KEEP_TRST = 1'b1,
    parameter bit FIXED_MODE = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tms_pin,
    input wire logic tck_pin,
    input wire logic tdi_pin,
    input wire logic trst_n_pin,
    input wire logic trst_pu_en,
    input wire logic user_tdo_out,
    input wire logic user_tdo_oe,
    output logic tdo_out,
    output logic tdo_oe,
    output logic test_active,
    output logic user_io_en,
    output logic user_trst_in,
    output logic [stp_pkg::STP_DR_W-1:0] probe_data,
    output logic probe_valid,
    input wire logic probe_ready,
    input wire logic [stp_pkg::STP_DR_W-1:0] scan_data,
    output logic [stp_pkg::STP_IR_W-1:0] ir_value,
    output logic checksum_busy
);
    import stp_pkg::*;
    // ********************************
    // Pin synchronisers
    // ********************************
    logic [1:0] tms_s_q, tck_s_q, tdi_s_q, trst_s_q;
    logic tck_prev_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            tms_s_q <= STP_SYNC_ONE;
            // Idle-high reset: release never shows a false test clock rise
            tck_s_q <= STP_SYNC_ONE;
            tdi_s_q <= STP_SYNC_ONE;
            trst_s_q <= STP_SYNC_ONE;
            tck_prev_q <= 1'b1;
        end else begin
            tms_s_q <= {tms_s_q[0], tms_pin};
            tck_s_q <= {tck_s_q[0], tck_pin};
            tdi_s_q <= {tdi_s_q[0], tdi_pin};
            // With trst_pu_en low the pin is ignored and reads high, reset idle
            trst_s_q <= {trst_s_q[0], trst_n_pin | ~trst_pu_en};
            tck_prev_q <= tck_s_q[1];
        end
    end

    logic tms, tdi, tck_rise, tck_fall, trst_act;
    assign tms = tms_s_q[1];
    assign tdi = tdi_s_q[1];
    assign tck_rise = tck_s_q[1] && !tck_prev_q;
    assign tck_fall = !tck_s_q[1] && tck_prev_q;
    // Sampled, not truly asynchronous to clk: acts regardless of test clock
    assign trst_act = KEEP_TRST && !trst_s_q[1];

    // ********************************
    // Pin ownership
    // ********************************
    logic claimed_q;
    stp_state_t st_q, st_d;
    always_ff @(posedge clk) begin
        if (rst || trst_act) begin
            claimed_q <= FIXED_MODE;
        end else if (FIXED_MODE) begin
            claimed_q <= 1'b1;
        end else if (!tms) begin
            claimed_q <= 1'b1;
        end else if (st_q == ST_RESET) begin
            claimed_q <= 1'b0;
        end
    end

    // ********************************
    // Test state machine
    // ********************************
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_RESET: st_d = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: st_d = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: st_d = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: st_d = tms ? ST_EX1_DR : ST_SHF_DR;
            ST_SHF_DR: st_d = tms ? ST_EX1_DR : ST_SHF_DR;
            ST_EX1_DR: st_d = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: st_d = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: st_d = tms ? ST_UPD_DR : ST_SHF_DR;
            ST_UPD_DR: st_d = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: st_d = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: st_d = tms ? ST_EX1_IR : ST_SHF_IR;
            ST_SHF_IR: st_d = tms ? ST_EX1_IR : ST_SHF_IR;
            ST_EX1_IR: st_d = tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: st_d = tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: st_d = tms ? ST_UPD_IR : ST_SHF_IR;
            ST_UPD_IR: st_d = tms ? ST_SEL_DR : ST_IDLE;
            default: st_d = ST_RESET;
        endcase
    end

    // Standard graph: five rises with select high land in reset
    always_ff @(posedge clk) begin
        if (rst || trst_act) begin
            st_q <= ST_RESET;
        end else if (tck_rise && claimed_q) begin
            st_q <= st_d;
        end
    end

    // ********************************
    // Instruction and data shifting
    // ********************************
    logic [STP_IR_W-1:0] ir_sh_q, ir_q;
    logic [STP_DR_W-1:0] dr_q;
    logic [STP_DR_W-1:0] sum_q;
    logic [$clog2(STP_DR_W)-1:0] bit_q;
    logic word_valid_q;
    logic fifo_in_ready;
    logic is_sum;
    assign is_sum = (ir_q == STP_IR_CHECKSUM);

    always_ff @(posedge clk) begin
        if (rst || trst_act) begin
            ir_sh_q <= STP_IR_RESET;
            ir_q <= STP_IR_RESET;
        end else if (tck_rise && claimed_q) begin
            // Entering logic reset restores the default instruction
            if (st_d == ST_RESET) begin
                ir_q <= STP_IR_RESET;
            end else if (st_q == ST_CAP_IR) begin
                ir_sh_q <= STP_IR_RESET;
            end else if (st_q == ST_SHF_IR) begin
                ir_sh_q <= {tdi, ir_sh_q[STP_IR_W-1:1]};
            end else if (st_q == ST_UPD_IR) begin
                ir_q <= ir_sh_q;
            end
        end
    end

    // Shift stalls while a finished word waits on a full FIFO; the tester's bits shifted meanwhile are dropped
    always_ff @(posedge clk) begin
        if (rst || trst_act) begin
            dr_q <= STP_DR_ZERO;
            bit_q <= '0;
            word_valid_q <= 1'b0;
            sum_q <= STP_SUM_INIT;
        end else begin
            if (word_valid_q && fifo_in_ready) begin
                word_valid_q <= 1'b0;
            end
            if (tck_rise && claimed_q) begin
                if (st_q == ST_CAP_DR) begin
                    dr_q <= is_sum ? sum_q : scan_data;
                    bit_q <= '0;
                end else if (st_q == ST_SHF_DR && !word_valid_q) begin
                    dr_q <= {tdi, dr_q[STP_DR_W-1:1]};
                    bit_q <= bit_q + 1'b1;
                    if (bit_q == ($clog2(STP_DR_W))'(STP_DR_W-1)) begin
                        word_valid_q <= 1'b1;
                        sum_q <= sum_q + {tdi, dr_q[STP_DR_W-1:1]};
                    end
                end
            end
        end
    end

    stp_fifo #(.WIDTH(STP_DR_W), .DEPTH(STP_FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_data(dr_q),
        .in_valid(word_valid_q),
        .in_ready(fifo_in_ready),
        .out_data(probe_data),
        .out_valid(probe_valid),
        .out_ready(probe_ready)
    );

    // ********************************
    // Output pins
    // ********************************
    logic shifting;
    assign shifting = (st_q == ST_SHF_DR) || (st_q == ST_SHF_IR);
    // While claimed, data out changes on test clock fall, as the tester samples on rise; unclaimed, it follows user logic each clk
    always_ff @(posedge clk) begin
        if (rst) begin
            tdo_out <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (claimed_q && is_sum) begin
            tdo_oe <= 1'b1;
            if (tck_fall) begin
                tdo_out <= dr_q[0];
            end
        end else if (claimed_q) begin
            tdo_oe <= shifting;
            if (tck_fall) begin
                tdo_out <= (st_q == ST_SHF_IR) ? ir_sh_q[0] : dr_q[0];
            end
        end else begin
            tdo_out <= user_tdo_out;
            tdo_oe <= user_tdo_oe;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            test_active <= FIXED_MODE;
            user_io_en <= !FIXED_MODE;
            user_trst_in <= 1'b1;
            ir_value <= STP_IR_RESET;
            checksum_busy <= 1'b0;
        end else begin
            test_active <= claimed_q;
            user_io_en <= !claimed_q;
            user_trst_in <= KEEP_TRST ? 1'b1 : trst_s_q[1];
            ir_value <= ir_q;
            checksum_busy <= claimed_q && is_sum;
        end
    end
endmodule : stp_ctrl

//--- verif/stp_ctrl_sva.sv
// Port assertions for the shared test pin controller.
// Assumes binding to stp_ctrl, with pins changed just after clk rises.
`timescale 1ns/1ps
module stp_chk
    import stp_pkg::*;
#(
    parameter bit FIXED = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tms_pin,
    input wire logic tck_pin,
    input wire logic trst_n_pin,
    input wire logic tdo_oe,
    input wire logic user_tdo_oe,
    input wire logic test_active,
    input wire logic user_io_en,
    input wire logic [stp_pkg::STP_DR_W-1:0] probe_data,
    input wire logic probe_valid,
    input wire logic probe_ready,
    input wire logic [stp_pkg::STP_IR_W-1:0] ir_value,
    input wire logic checksum_busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic tck_q;
    logic [2:0] hi_cnt_q;
    // ****************************
    // Select-high counter
    // ****************************
    always_ff @(posedge clk) begin
        tck_q <= tck_pin;
    end
    // Sees test clock rises before the design does, so it never lags
    always_ff @(posedge clk) begin
        if (rst || trst_n_pin == 1'b0) begin
            hi_cnt_q <= 3'h5;
        end else if (tck_pin && !tck_q) begin
            hi_cnt_q <= !tms_pin ? 3'h0 : (hi_cnt_q == 3'h5 ? 3'h5 : hi_cnt_q + 3'h1);
        end
    end
    // ****************************
    // Properties
    // ****************************
    a_claim_time: assert property (
        $fell(tms_pin) ##1 !tms_pin [*4] |-> ##[0:4] test_active) else $error("no claim");
    a_claim_cause: assert property (
        $rose(test_active) |-> !$past(tms_pin, 4)) else $error("claim without select low");
    a_io_swap: assert property (
        user_io_en == !test_active) else $error("user enable not inverse of claim");
    a_drop_five: assert property (
        $rose(hi_cnt_q == 3'h5) && !FIXED |-> ##[1:8] !test_active)
        else $error("pins not released");
    a_probe_hold: assert property (
        probe_valid && !probe_ready |=> probe_valid && $stable(probe_data))
        else $error("probe word lost while stalled");
    a_cks_drive: assert property (
        $rose(checksum_busy) |-> ##[0:2] (tdo_oe && ir_value == STP_IR_CHECKSUM) [*3])
        else $error("checksum not driving data out");
    a_reset_ir: assert property (
        $fell(test_active) |-> ##[0:2] (ir_value == STP_IR_RESET && !checksum_busy))
        else $error("instruction not reset on release");
    a_tdo_release: assert property (
        $fell(test_active) |-> ##[0:2] (tdo_oe == $past(user_tdo_oe)))
        else $error("data out not back with user logic");
    c_claim: cover property ($rose(test_active));
    c_checksum: cover property ($rose(checksum_busy));
    c_pop: cover property (probe_valid && probe_ready);
endmodule : stp_chk
bind stp_ctrl stp_chk #(.FIXED(FIXED_MODE)) u_chk (.clk(clk), .rst(rst), .tms_pin(tms_pin),
    .tck_pin(tck_pin), .trst_n_pin(trst_n_pin), .tdo_oe(tdo_oe),
    .user_tdo_oe(user_tdo_oe), .test_active(test_active),
    .user_io_en(user_io_en), .probe_data(probe_data), .probe_valid(probe_valid),
    .probe_ready(probe_ready), .ir_value(ir_value), .checksum_busy(checksum_busy));

//--- verif/stp_tester.sv
// Boundary-scan tester model: select, test clock and data in.
// Assumes its task is entered just after a rising clk edge.
`timescale 1ns/1ps
module stp_tester (
    input wire logic clk,
    input wire logic tdo_out,
    output logic tms_pin,
    output logic tck_pin,
    output logic tdi_pin
);
    initial begin
        tms_pin = 1'b1;
        tck_pin = 1'b1;
        tdi_pin = 1'b0;
    end
    // ****************************
    // Test clock frames
    // ****************************
    // Eight clk per test clock; the clock stands high between frames
    task automatic walk(input logic [15:0] tms_v, input logic [15:0] tdi_v,
                        input int n, output logic [15:0] tdo_v);
        tdo_v = 16'h0000;
        for (int i = 0; i < n; i++) begin
            tck_pin = 1'b0;
            tms_pin = tms_v[i];
            tdi_pin = tdi_v[i];
            repeat (4) @(posedge clk);
            tdo_v[i] = tdo_out;
            #1 tck_pin = 1'b1;
            repeat (4) @(posedge clk);
            #1;
        end
    endtask : walk
endmodule : stp_tester

//--- verif/testbench.sv
// Self-checking bench for the shared test pin controller.
// Assumes the tester model and the checker are compiled before it.
`timescale 1ns/1ps
module testbench;
    import stp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic trst_drive = 1'b0;
    logic probe_ready = 1'b0;
    logic user_oe = 1'b0;
    logic user_out = 1'b0;
    logic fx_active, fx_trst_in;
    logic [STP_DR_W-1:0] scan_data = 8'h96;
    wire trst_n_pin;
    logic tms_pin, tck_pin, tdi_pin, tdo_out, tdo_oe, test_active, user_io_en;
    logic user_trst_in, probe_valid, checksum_busy;
    logic [STP_DR_W-1:0] probe_data;
    logic [STP_IR_W-1:0] ir_value;
    logic [15:0] tdo_v;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    // Rows: word shifted in, word expected at the probe output
    logic [15:0] rows [8] = '{16'h0000, 16'hFFFF, 16'h8080, 16'h0101, 16'hA5A5, 16'h5A5A,
        16'h3C3C, 16'hC3C3};
    // Pull-up: the line is high unless the bench pulls it low
    assign trst_n_pin = trst_drive ? 1'b0 : 1'b1;
    stp_ctrl #(.KEEP_TRST(1'b1), .FIXED_MODE(1'b0)) uut (.clk(clk), .rst(rst),
        .tms_pin(tms_pin), .tck_pin(tck_pin), .tdi_pin(tdi_pin), .trst_n_pin(trst_n_pin),
        .trst_pu_en(1'b1), .user_tdo_out(user_out), .user_tdo_oe(user_oe), .tdo_out(tdo_out),
        .tdo_oe(tdo_oe), .test_active(test_active), .user_io_en(user_io_en),
        .user_trst_in(user_trst_in), .probe_data(probe_data), .probe_valid(probe_valid),
        .probe_ready(probe_ready), .scan_data(scan_data), .ir_value(ir_value),
        .checksum_busy(checksum_busy));
    // Fixed-mode twin without the reset pin option, sharing the same tester
    stp_ctrl #(.KEEP_TRST(1'b0), .FIXED_MODE(1'b1)) uut_fixed (.clk(clk), .rst(rst),
        .tms_pin(tms_pin), .tck_pin(tck_pin), .tdi_pin(tdi_pin), .trst_n_pin(trst_n_pin),
        .trst_pu_en(1'b1), .user_tdo_out(user_out), .user_tdo_oe(user_oe), .tdo_out(),
        .tdo_oe(), .test_active(fx_active), .user_io_en(), .user_trst_in(fx_trst_in),
        .probe_data(), .probe_valid(), .probe_ready(probe_ready), .scan_data(scan_data),
        .ir_value(), .checksum_busy());
    stp_tester u_tst (.clk(clk), .tdo_out(tdo_out), .tms_pin(tms_pin), .tck_pin(tck_pin),
        .tdi_pin(tdi_pin));
    always #50 clk = ~clk;
    // ****************************
    // Helpers
    // ****************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            $display("Error at %0t ns: run hung", $time);
            end_sim();
        end
    end
    // ****************************
    // Sequence
    // ****************************
    initial begin
        settle(20);
        rst = 1'b0;
        chk(test_active, 1'b0);
        chk(ir_value, STP_IR_RESET);
        chk(tdo_oe, 1'b0);
        chk(user_trst_in, 1'b1);
        u_tst.walk(16'h0002, 16'h0000, 4, tdo_v);
        chk(user_io_en, 1'b0);
        for (int i = 0; i < 8; i++) begin
            u_tst.walk(16'h0000, {8'h00, rows[i][15:8]}, 8, tdo_v);
            if (i == 0) begin
                chk(tdo_v[7:0], scan_data);
                chk(tdo_oe, 1'b1);
            end
        end
        // Ninth word meets a full buffer and must not disturb it
        u_tst.walk(16'h0000, 16'h00EE, 8, tdo_v);
        chk(probe_valid, 1'b1);
        probe_ready = 1'b1;
        for (int i = 0; i < 8; i++) begin
            chk(probe_data, rows[i][7:0]);
            settle(1);
        end
        for (int k = 0; k < 8 && probe_valid === 1'b1; k++) begin
            settle(1);
        end
        probe_ready = 1'b0;
        chk(probe_valid, 1'b0);
        u_tst.walk(16'h000F, 16'h0000, 4, tdo_v);
        chk(test_active, 1'b1);
        u_tst.walk(16'h0001, 16'h0000, 1, tdo_v);
        settle(4);
        chk(user_io_en, 1'b1);
        user_oe = 1'b1;
        user_out = 1'b1;
        settle(2);
        chk(tdo_oe, 1'b1);
        chk(tdo_out, 1'b1);
        chk(fx_active, 1'b1);
        user_oe = 1'b0;
        user_out = 1'b0;
        u_tst.walk(16'h0306, 16'h0180, 11, tdo_v);
        settle(2);
        chk(checksum_busy, 1'b1);
        chk(tdo_oe, 1'b1);
        u_tst.walk(16'h001F, 16'h0000, 5, tdo_v);
        settle(4);
        chk(tdo_oe, 1'b0);
        chk(checksum_busy, 1'b0);
        u_tst.walk(16'h0012, 16'h0000, 5, tdo_v);
        chk(test_active, 1'b1);
        trst_drive = 1'b1;
        settle(6);
        chk(test_active, 1'b0);
        chk(ir_value, STP_IR_RESET);
        chk(fx_trst_in, 1'b0);
        chk(fx_active, 1'b1);
        trst_drive = 1'b0;
        settle(6);
        chk(user_io_en, 1'b1);
        chk(fx_trst_in, 1'b1);
        end_sim();
    end
endmodule : testbench
